/* dqst_top.sv */
// Strobe interval oscillator and read preamble training logic.
// Assumes a command decoder on ck_clk hands over decoded multi-purpose,
// CAS-2, mode register write and read strobes, plus read latency.
// Operation
// R1 - Start command starts the replica clock-tree oscillator counter.
// R2 - Oscillator stops on stop command or after programmed automatic run length.
// R3 - Controller never sends stop while automatic stop is programmed.
// R4 - On any stop, final count is copied into both result registers.
// R5 - Low result register holds count LSB byte, high register holds MSB byte.
// R6 - A stop command overwrites both result registers.
// R7 - Counter saturates at its maximum instead of wrapping.
// R8 - Controller discards a saturated count as overflow.
// R9 - Controller runs the oscillator at least 200 ns for matching checks.
// R10 - Controller waits readout delay, max of 40 ns and 8 clocks, before reading.
// R11 - Controller waits readout delay after stop before a new start.
// R12 - Training enable drives strobe true low, complement high until calibration.
// R13 - Training omits preamble; calibration toggles strobes like a read burst.
// R14 - Controller sends only calibration commands during preamble training.
// R15 - Calibration command is followed at once by CAS-2 with low operands.
// R16 - Each calibration returns first pattern then second pattern after read latency.
// R17 - Pattern is inverted on lanes whose invert mask bit is one.
// R18 - Pattern also drives mask pins, never with bus inversion applied.
// R19 - Calibration commands may repeat seamlessly; bursts follow back to back.
// R20 - Clearing training enable leaves training within the strobe drive delay.
// R21 - Start and stop oscillator operands decoded, no CAS-2 needed.
// R22 - Calibration command recognised by its seven-bit operand code.
// R23 - Training read latency counts from the CAS-2 command edge.
// R24 - Counter clears to zero when a start command is accepted.
// R25 - Result registers are read-only; writes to them are ignored.
`timescale 1ns/1ps
`include "dqst_consts.svh"
module dqst_top
   import dqst_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        ck_clk,
   input  wire logic        mpc_valid,
   input  wire logic [6:0]  mpc_op,
   input  wire logic        cas2_valid,
   input  wire logic        mrw_valid,
   input  wire logic [5:0]  mrw_addr,
   input  wire logic [7:0]  mrw_data,
   input  wire logic        mrr_valid,
   input  wire logic [5:0]  mrr_addr,
   input  wire logic [4:0]  rd_latency,
   input  wire logic        rd_dbi_en,
   output logic [7:0]       mrr_data,
   output logic             mrr_data_valid,
   output logic             osc_busy,
   output logic [1:0]       dqs_t_pair,
   output logic [1:0]       dqs_c_pair,
   output logic             dqs_oe,
   output logic [7:0]       dq_first,
   output logic [7:0]       dq_second,
   output logic             dq_oe,
   output logic [1:0]       dmi_pair,
   output logic             dmi_oe
);
   localparam int SDO_NCK = `SDO_CK_CYC;

   // ====================================================
   // Lane pattern function
   // Every lane carries the same bit, flipped where the mask asks
   function automatic logic [7:0] lane_bits
   (
      input logic       bit_v,
      input logic [7:0] mask
   );
      lane_bits = {8{bit_v}} ^ mask;
   endfunction

   // ====================================================
   // Declarations
   dqst_ck_t    st_ff;
   dqst_ck_t    nxt_st;
   logic        ck_rst;
   logic        run_s;
   logic        done_s;
   logic        done_tgl;
   logic [15:0] count_hold;
   logic        cal_trig;
   logic        burst_go;
   logic        copy_res;
   logic        go_cmd;
   logic        halt_cmd;
   logic [11:0] auto_lim;
   logic [15:0] pat;
   logic        beat_a;
   logic        beat_b;

   // ====================================================
   // Clock domain crossings
   // Reset reaches the link side through two flops; it must be held
   // long enough to cover a few link clock edges
   dqst_sync u_rst_sync
   (
      .clk (ck_clk),
      .rst (1'b0),
      .d   (srst),
      .q   (ck_rst)
   );

   // Run level to the counter domain
   dqst_sync u_run_sync
   (
      .clk (sys_clk),
      .rst (srst),
      .d   (st_ff.osc_run),
      .q   (run_s)
   );

   // Stop toggle back to the link; the hold word is quiet by then
   dqst_sync u_done_sync
   (
      .clk (ck_clk),
      .rst (ck_rst),
      .d   (done_tgl),
      .q   (done_s)
   );

   dqst_osc u_osc
   (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .run_s      (run_s),
      .count_hold (count_hold),
      .done_tgl   (done_tgl)
   );

   // ====================================================
   // Command decode helpers
   assign go_cmd   = mpc_valid && (mpc_op == `OP_OSC_GO);   // R21
   assign halt_cmd = mpc_valid && (mpc_op == `OP_OSC_HALT); // R21
   assign cal_trig = st_ff.cal_pend && cas2_valid;          // R15 R23
   assign burst_go = st_ff.pipe[rd_latency];                // R23
   assign copy_res = done_s ^ st_ff.done_seen;
   assign auto_lim = {st_ff.run_len, `RUNLEN_PAD} - `AUTO_ONE;
   assign pat      = {st_ff.pat1, st_ff.pat0};

   // ====================================================
   // Next state
   always_comb
   begin
      nxt_st = st_ff;

      // Calibration waits one cycle for its CAS-2 partner
      nxt_st.cal_pend = mpc_valid && (mpc_op == `OP_CAL);   // R22
      nxt_st.pipe     = {st_ff.pipe[`PIPE_W-2:0], cal_trig}; // R23

      // Oscillator run control
      if (go_cmd)
      begin
         nxt_st.osc_run  = 1'b1;                            // R1
         nxt_st.auto_cnt = 12'h000;
      end
      else if (halt_cmd)
         nxt_st.osc_run = 1'b0;                             // R2
      else if (st_ff.osc_run && st_ff.run_len != `RUNLEN_OFF)
      begin
         if (st_ff.auto_cnt == auto_lim)
            nxt_st.osc_run = 1'b0;                          // R2
         else
            nxt_st.auto_cnt = st_ff.auto_cnt + `AUTO_ONE;
      end

      // Result capture after each stop, whatever caused it
      nxt_st.done_seen = done_s;
      if (copy_res)
      begin
         nxt_st.res_lo = count_hold[7:0];                   // R4 R5 R6
         nxt_st.res_hi = count_hold[15:8];                  // R5
      end

      // Mode register writes; result addresses fall to default
      if (mrw_valid)
      begin
         case (mrw_addr)
            `MR_RUNLEN: nxt_st.run_len = mrw_data;
            `MR_TCTL:   nxt_st.tctl    = mrw_data;
            `MR_INV:    nxt_st.inv     = mrw_data;
            `MR_PAT0:   nxt_st.pat0    = mrw_data;
            `MR_PAT1:   nxt_st.pat1    = mrw_data;
            default:    nxt_st.run_len = st_ff.run_len;      // R25
         endcase
      end

      // Mode register reads; unmapped addresses read zero
      nxt_st.mrr_vld = mrr_valid;
      if (mrr_valid)
      begin
         case (mrr_addr)
            `MR_RES_LO: nxt_st.mrr_data = st_ff.res_lo;      // R25
            `MR_RES_HI: nxt_st.mrr_data = st_ff.res_hi;      // R25
            `MR_RUNLEN: nxt_st.mrr_data = st_ff.run_len;
            `MR_TCTL:   nxt_st.mrr_data = st_ff.tctl;
            `MR_INV:    nxt_st.mrr_data = st_ff.inv;
            `MR_PAT0:   nxt_st.mrr_data = st_ff.pat0;
            `MR_PAT1:   nxt_st.mrr_data = st_ff.pat1;
            default:    nxt_st.mrr_data = 8'h00;
         endcase
      end

      // Burst sequencer: a new start restarts at beat zero,
      // which gives seamless bursts at the column interval
      if (burst_go)
      begin
         nxt_st.bact = 1'b1;                                // R19
         nxt_st.bcnt = 3'h0;
      end
      else if (st_ff.bact)
      begin
         if (st_ff.bcnt == `BURST_LAST)
            nxt_st.bact = 1'b0;
         else
            nxt_st.bcnt = st_ff.bcnt + `BURST_ONE;
      end

      // Two beats per link clock, low-order bit first
      beat_a = pat[{nxt_st.bcnt, 1'b0}];                    // R16
      beat_b = pat[{nxt_st.bcnt, 1'b1}];                    // R16

      // Pin drive: burst, static training level, or released
      if (nxt_st.bact)
      begin
         nxt_st.dqs_t     = `DQS_T_BURST;                   // R13
         nxt_st.dqs_c     = ~`DQS_T_BURST;
         nxt_st.dqs_oe    = 1'b1;
         nxt_st.dq_first  = lane_bits(beat_a, st_ff.inv);   // R17
         nxt_st.dq_second = lane_bits(beat_b, st_ff.inv);   // R17
         nxt_st.dq_oe     = 1'b1;
         nxt_st.mask_inversion_pin       = {beat_a, beat_b};               // R18
         nxt_st.dmi_oe    = rd_dbi_en;
      end
      else if (nxt_st.tctl[`TCTL_PRE_BIT])
      begin
         nxt_st.dqs_t     = `DQS_T_HOLD;                    // R12 R13
         nxt_st.dqs_c     = ~`DQS_T_HOLD;
         nxt_st.dqs_oe    = 1'b1;
         nxt_st.dq_first  = 8'h00;
         nxt_st.dq_second = 8'h00;
         nxt_st.dq_oe     = 1'b0;
         nxt_st.mask_inversion_pin       = `DQS_LOW2;
         nxt_st.dmi_oe    = 1'b0;
      end
      else
      begin
         nxt_st.dqs_t     = `DQS_LOW2;                      // R20
         nxt_st.dqs_c     = `DQS_LOW2;
         nxt_st.dqs_oe    = 1'b0;
         nxt_st.dq_first  = 8'h00;
         nxt_st.dq_second = 8'h00;
         nxt_st.dq_oe     = 1'b0;
         nxt_st.mask_inversion_pin       = `DQS_LOW2;
         nxt_st.dmi_oe    = 1'b0;
      end
   end

   // ====================================================
   // State register on the link clock
   always_ff @(posedge ck_clk)
   begin
      if (ck_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // ====================================================
   // Outputs, all straight from the state register
   assign mrr_data       = st_ff.mrr_data;
   assign mrr_data_valid = st_ff.mrr_vld;
   assign osc_busy       = st_ff.osc_run;
   assign dqs_t_pair     = st_ff.dqs_t;
   assign dqs_c_pair     = st_ff.dqs_c;
   assign dqs_oe         = st_ff.dqs_oe;
   assign dq_first       = st_ff.dq_first;
   assign dq_second      = st_ff.dq_second;
   assign dq_oe          = st_ff.dq_oe;
   assign dmi_pair       = st_ff.mask_inversion_pin;
   assign dmi_oe         = st_ff.dmi_oe;

   // ====================================================
   // Checks
   AST_OSC_GO: assert property (@(posedge ck_clk) disable iff (ck_rst)
      go_cmd |=> st_ff.osc_run && st_ff.auto_cnt == 12'h000)
      else $error("start command did not run oscillator"); // R1
   AST_OSC_HALT: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (halt_cmd && !go_cmd) |=> !st_ff.osc_run)
      else $error("stop command ignored"); // R2
   AST_OSC_AUTO: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (st_ff.osc_run && !mpc_valid && st_ff.run_len != `RUNLEN_OFF
       && st_ff.auto_cnt == auto_lim) |=> !st_ff.osc_run)
      else $error("automatic stop missed"); // R2
   AST_RES_COPY: assert property (@(posedge ck_clk) disable iff (ck_rst)
      copy_res |=> {st_ff.res_hi, st_ff.res_lo} == $past(count_hold))
      else $error("result registers not loaded"); // R4
   AST_RES_RO: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (mrw_valid && !copy_res
       && (mrw_addr == `MR_RES_LO || mrw_addr == `MR_RES_HI))
      |=> $stable(st_ff.res_lo) && $stable(st_ff.res_hi))
      else $error("write changed result register"); // R25
   AST_TR_HOLD: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (nxt_st.tctl[`TCTL_PRE_BIT] && !nxt_st.bact)
      |=> st_ff.dqs_oe && st_ff.dqs_t == 2'h0 && st_ff.dqs_c == 2'h3)
      else $error("training strobe level wrong"); // R12
   AST_TR_EXIT: assert property (@(posedge ck_clk) disable iff (ck_rst)
      ($fell(st_ff.tctl[`TCTL_PRE_BIT]) && st_ff.pipe == 32'h0 && !burst_go)
      |-> ##[0:SDO_NCK] !st_ff.dqs_oe)
      else $error("training not left in time"); // R20
   AST_CAL_LAT: assert property (@(posedge ck_clk) disable iff (ck_rst)
      burst_go |=> st_ff.bact && st_ff.bcnt == 3'h0 && st_ff.dqs_t == 2'h2)
      else $error("burst did not start at latency"); // R23
   AST_CAL_LEN: assert property (@(posedge ck_clk) disable iff (ck_rst)
      $rose(st_ff.bact) |-> st_ff.bact [*8])
      else $error("burst shorter than sixteen beats"); // R16 R19
   // Pattern checks skip the cycle after a mode register write: the pins
   // were built from the pattern as it stood before that write
   AST_CAL_DATA: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (st_ff.bact && st_ff.bcnt == 3'h0 && !$past(mrw_valid))
      |-> st_ff.dq_first == ({8{st_ff.pat0[0]}} ^ st_ff.inv)
      && st_ff.dq_second == ({8{st_ff.pat0[1]}} ^ st_ff.inv)
      && st_ff.mask_inversion_pin == {st_ff.pat0[0], st_ff.pat0[1]})
      else $error("first beats of pattern wrong"); // R17 R18
   AST_DMI_PLAIN: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (st_ff.bact && !$past(mrw_valid))
      |-> st_ff.mask_inversion_pin == {pat[{st_ff.bcnt, 1'b0}], pat[{st_ff.bcnt, 1'b1}]}
      && st_ff.dmi_oe == $past(rd_dbi_en))
      else $error("mask pins carry altered pattern"); // R18
   AST_CAL_STROBE: assert property (@(posedge ck_clk) disable iff (ck_rst)
      st_ff.bact |-> st_ff.dqs_oe && st_ff.dq_oe
      && st_ff.dqs_t == 2'h2 && st_ff.dqs_c == 2'h1)
      else $error("burst strobes not toggling"); // R13
   AST_TR_OFF: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (!st_ff.tctl[`TCTL_PRE_BIT] && !st_ff.bact)
      |-> !st_ff.dqs_oe && !st_ff.dq_oe && !st_ff.dmi_oe)
      else $error("pins driven outside training"); // R20
   AST_RES_RD_LO: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (mrr_valid && mrr_addr == `MR_RES_LO)
      |=> mrr_data_valid && mrr_data == $past(st_ff.res_lo))
      else $error("low result byte read wrong"); // R5
   AST_RES_RD_HI: assert property (@(posedge ck_clk) disable iff (ck_rst)
      (mrr_valid && mrr_addr == `MR_RES_HI)
      |=> mrr_data_valid && mrr_data == $past(st_ff.res_hi))
      else $error("high result byte read wrong"); // R5
endmodule

/* dqst_consts.svh */
// Constants for the strobe oscillator and preamble training block.
// Assumes mode register addresses arrive as 6-bit values from the decoder.
`ifndef DQST_CONSTS_SVH
`define DQST_CONSTS_SVH
// ====================================================
// Mode register addresses
`define MR_RES_LO      6'h12
`define MR_RES_HI      6'h13
`define MR_RUNLEN      6'h17
`define MR_TCTL        6'h0d
`define MR_INV         6'h0f
`define MR_PAT0        6'h20
`define MR_PAT1        6'h28
// ====================================================
// Multi-purpose operand codes
`define OP_CAL         7'h43
`define OP_OSC_GO      7'h4b
`define OP_OSC_HALT    7'h4d
// ====================================================
// Fields and values
`define TCTL_PRE_BIT   1
`define CNT_MAX        16'hffff
`define CNT_ZERO       16'h0000
`define RUNLEN_OFF     8'h00
`define RUNLEN_PAD     4'h0
`define AUTO_ONE       12'h001
`define BURST_LAST     3'h7
`define BURST_ONE      3'h1
`define PIPE_W         32
`define DQS_T_BURST    2'h2
`define DQS_T_HOLD     2'h0
`define DQS_LOW2       2'h0
// ====================================================
// Timing: strobe drive delay, longest figure
`define T_SDO_NCK      12
`define T_SDO_NS       20
`define CK_NS          80
`define SDO_CK_CYC     (((`T_SDO_NS) / (`CK_NS)) > (`T_SDO_NCK) ? \
                        ((`T_SDO_NS) / (`CK_NS)) : (`T_SDO_NCK))
`endif

/* dqst_pkg.sv */
// Types for the strobe oscillator and preamble training block.
// Assumes the constants header is available to every design file.
package dqst_pkg;
   // ====================================================
   // Synchroniser stages
   typedef struct packed {
      logic s1;
      logic s2;
   } dqst_sync_t;
   // ====================================================
   // Replica oscillator counter state
   typedef struct packed {
      logic        run_d;
      logic [15:0] cnt;
      logic [15:0] hold;
      logic        done_tgl;
   } dqst_osc_t;
   // ====================================================
   // Link-side state
   typedef struct packed {
      logic [7:0]  run_len;
      logic [7:0]  tctl;
      logic [7:0]  inv;
      logic [7:0]  pat0;
      logic [7:0]  pat1;
      logic [7:0]  res_lo;
      logic [7:0]  res_hi;
      logic        osc_run;
      logic [11:0] auto_cnt;
      logic        done_seen;
      logic        cal_pend;
      logic [31:0] pipe;
      logic        bact;
      logic [2:0]  bcnt;
      logic [7:0]  mrr_data;
      logic        mrr_vld;
      logic [1:0]  dqs_t;
      logic [1:0]  dqs_c;
      logic        dqs_oe;
      logic [7:0]  dq_first;
      logic [7:0]  dq_second;
      logic        dq_oe;
      logic [1:0]  mask_inversion_pin;
      logic        dmi_oe;
   } dqst_ck_t;
endpackage

/* dqst_sync.sv */
// Two-stage level synchroniser.
// Assumes d is a level that stays put for several cycles of clk.
`timescale 1ns/1ps
module dqst_sync
   import dqst_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   dqst_sync_t st_ff;
   dqst_sync_t nxt_st;

   // First stage feeds only the second
   always_comb
   begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q = st_ff.s2;
endmodule

/* dqst_osc.sv */
// Replica clock-tree oscillator counter, modelled on sys_clk ticks.
// Assumes run_s is already synchronised into the sys_clk domain.
`timescale 1ns/1ps
`include "dqst_consts.svh"
module dqst_osc
   import dqst_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        run_s,
   output logic [15:0]      count_hold,
   output logic             done_tgl
);
   dqst_osc_t st_ff;
   dqst_osc_t nxt_st;

   // Count while running; hold copy only changes on a stop edge,
   // so the link side can read it after seeing the toggle
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.run_d = run_s;
      if (run_s && !st_ff.run_d)
         nxt_st.cnt = `CNT_ZERO;                         // R24
      else if (run_s && st_ff.cnt != `CNT_MAX)
         nxt_st.cnt = st_ff.cnt + 16'h0001;              // R1 R7
      if (!run_s && st_ff.run_d)
      begin
         nxt_st.hold     = st_ff.cnt;                    // R4
         nxt_st.done_tgl = ~st_ff.done_tgl;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign count_hold = st_ff.hold;
   assign done_tgl   = st_ff.done_tgl;

   AST_OSC_SAT: assert property (@(posedge sys_clk) disable iff (srst)
      (st_ff.cnt == `CNT_MAX && run_s && st_ff.run_d) |=> st_ff.cnt == `CNT_MAX)
      else $error("counter left saturation"); // R7
   AST_OSC_CLR: assert property (@(posedge sys_clk) disable iff (srst)
      (run_s && !st_ff.run_d) |=> st_ff.cnt == `CNT_ZERO)
      else $error("counter not cleared on start"); // R24
   AST_OSC_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      (!run_s && st_ff.run_d) |=> (st_ff.hold == $past(st_ff.cnt))
      && (st_ff.done_tgl != $past(st_ff.done_tgl)))
      else $error("stop did not capture count"); // R4
endmodule

/* dqst_ctrl_model.sv */
// Controller-side model: drives decoded commands and register accesses on the link clock.
// Assumes every task is entered 1 ns after a rising edge of ck_clk.
`timescale 1ns/1ps
`include "dqst_consts.svh"
module dqst_ctrl_model
(
   input  wire logic       ck_clk,
   output logic            mpc_valid,
   output logic [6:0]      mpc_op,
   output logic            cas2_valid,
   output logic            mrw_valid,
   output logic [5:0]      mrw_addr,
   output logic [7:0]      mrw_data,
   output logic            mrr_valid,
   output logic [5:0]      mrr_addr,
   input  wire logic [7:0] mrr_data,
   input  wire logic       mrr_data_valid
);
   // ==========================================================
   // Command drivers
   initial
   begin
      {mpc_valid, mpc_op, cas2_valid, mrw_valid, mrw_addr, mrw_data} = '0;
      {mrr_valid, mrr_addr} = '0;
   end

   // Hold for one edge, then scramble released fields so stale values never pass;
   // one idle edge follows so no strobe is lowered and raised in one time step
   task automatic step();
      @(posedge ck_clk);
      #1;
      {mpc_valid, cas2_valid, mrw_valid, mrr_valid} = '0;
      mpc_op = ~mpc_op;
      mrw_addr = ~mrw_addr;
      mrw_data = ~mrw_data;
      mrr_addr = ~mrr_addr;
      @(posedge ck_clk);
      #1;
   endtask

   // Oscillator start and stop need no CAS-2
   task automatic mpc(logic [6:0] op);
      mpc_valid = 1'b1;
      mpc_op = op;
      step();
   endtask

   // Calibration is always followed at once by CAS-2 with operands low
   task automatic cal();
      mpc_valid = 1'b1;
      mpc_op = `OP_CAL;
      @(posedge ck_clk);
      #1;
      mpc_valid = 1'b0;
      cas2_valid = 1'b1;
      step();
   endtask

   task automatic mrw(logic [5:0] a, logic [7:0] d);
      mrw_valid = 1'b1;
      mrw_addr = a;
      mrw_data = d;
      step();
   endtask

   // Answer stands for the cycle after the request edge and is taken there
   task automatic mrr(logic [5:0] a, output logic [7:0] d, output logic ok);
      mrr_valid = 1'b1;
      mrr_addr = a;
      @(posedge ck_clk);
      #1;
      mrr_valid = 1'b0;
      d = mrr_data;
      ok = mrr_data_valid;
      @(posedge ck_clk);
      #1;
   endtask
endmodule

/* dqst_top_tb.sv */
// Self-checking bench for the strobe oscillator and preamble training block.
// Assumes the controller model supplies every command; latency and inversion are tied.
`timescale 1ns/1ps
`include "dqst_consts.svh"
module dqst_top_tb
   import dqst_pkg::*;
;
   logic       sys_clk, srst, ck_clk, mpc_valid, cas2_valid, mrw_valid, mrr_valid;
   logic [6:0] mpc_op;
   logic [5:0] mrw_addr, mrr_addr;
   logic [7:0] mrw_data, mrr_data, dq_first, dq_second, lo, hi;
   logic [4:0] rd_latency;
   logic       rd_dbi_en, mrr_data_valid, osc_busy, dqs_oe, dq_oe, dmi_oe, ok;
   logic [1:0] dqs_t_pair, dqs_c_pair, dmi_pair;
   logic [15:0] c;
   logic [15:0] pat;
   int         num_errors = 0;
   int         num_checks = 0;
   int         cyc = 0;

   dqst_top dut (.sys_clk(sys_clk), .srst(srst), .ck_clk(ck_clk), .mpc_valid(mpc_valid),
      .mpc_op(mpc_op), .cas2_valid(cas2_valid), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
      .mrw_data(mrw_data), .mrr_valid(mrr_valid), .mrr_addr(mrr_addr),
      .rd_latency(rd_latency), .rd_dbi_en(rd_dbi_en), .mrr_data(mrr_data),
      .mrr_data_valid(mrr_data_valid), .osc_busy(osc_busy), .dqs_t_pair(dqs_t_pair),
      .dqs_c_pair(dqs_c_pair), .dqs_oe(dqs_oe), .dq_first(dq_first), .dq_second(dq_second),
      .dq_oe(dq_oe), .dmi_pair(dmi_pair), .dmi_oe(dmi_oe));

   dqst_ctrl_model u_ctrl (.ck_clk(ck_clk), .mpc_valid(mpc_valid), .mpc_op(mpc_op),
      .cas2_valid(cas2_valid), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
      .mrw_data(mrw_data), .mrr_valid(mrr_valid), .mrr_addr(mrr_addr),
      .mrr_data(mrr_data), .mrr_data_valid(mrr_data_valid));

   // ==========================================================
   // Clocks and hang guard; link clock offset so no link clock edge meets a sys_clk edge
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial
   begin
      ck_clk = 1'b0;
      #13;
      forever #40 ck_clk = ~ck_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         num_errors++;
         finish_test();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_ck(int k);
      repeat (k) @(posedge ck_clk);
      #1;
   endtask

   task automatic rd(logic [5:0] a, output logic [7:0] d);
      u_ctrl.mrr(a, d, ok);
      check("mrr_data_valid", 16'(ok), 16'h1);
   endtask

   // Low byte then high byte; after a stop, callers wait the readout delay first
   task automatic rd_count(output logic [15:0] v);
      rd(`MR_RES_LO, lo);
      rd(`MR_RES_HI, hi);
      v = {hi, lo};
   endtask

   // Oscillator counts sys_clk ticks, 20 per link cycle; start to stop is n cycles
   task automatic osc_meas(int n, output logic [15:0] v);
      u_ctrl.mpc(`OP_OSC_GO);
      wait_ck(n - 2);
      check("osc_busy run", 16'(osc_busy), 16'h1);
      u_ctrl.mpc(`OP_OSC_HALT);
      check("osc_busy halt", 16'(osc_busy), 16'h0);
      wait_ck(8);
      rd_count(v);
   endtask

   task automatic near(string what, logic [15:0] v, int exp);
      check(what, 16'(v >= 16'(exp - 24) && v <= 16'(exp + 24)), 16'h1);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      srst = 1'b1;
      rd_latency = 5'h04;
      rd_dbi_en = 1'b1;
      repeat (10) @(posedge ck_clk);
      @(posedge sys_clk);
      #1;
      srst = 1'b0;
      wait_ck(3);
      rd_count(c);
      check("count after reset", c, 16'h0000);
      rd(6'h3f, lo);
      check("unmapped read", 16'(lo), 16'h0000);
      $display("test registers done");

      osc_meas(20, c);
      near("count 20 cycles", c, 400);
      u_ctrl.mrw(`MR_RES_LO, ~c[7:0]);
      rd(`MR_RES_LO, lo);
      check("result write ignored", 16'(lo), 16'(c[7:0]));
      wait_ck(8);
      osc_meas(12, c);
      near("count cleared at start", c, 240);
      $display("test manual stop done");

      u_ctrl.mrw(`MR_RUNLEN, 8'h01);
      u_ctrl.mpc(`OP_OSC_GO);
      wait_ck(14);
      check("osc_busy auto run", 16'(osc_busy), 16'h1);
      wait_ck(6);
      check("osc_busy auto stop", 16'(osc_busy), 16'h0);
      wait_ck(8);
      rd_count(c);
      near("count auto stop", c, 320);
      $display("test auto stop done");

      u_ctrl.mrw(`MR_RUNLEN, 8'h00);
      osc_meas(3400, c);
      check("count saturated", c, 16'hffff);
      $display("test saturation done");

      pat = 16'ha527;
      u_ctrl.mrw(`MR_PAT0, pat[7:0]);
      u_ctrl.mrw(`MR_PAT1, pat[15:8]);
      u_ctrl.mrw(`MR_INV, 8'h55);
      u_ctrl.mrw(`MR_TCTL, 8'h02);
      wait_ck(2);
      check("static strobe", {11'h0, dqs_t_pair, dqs_c_pair, dqs_oe}, 16'h0007);
      // Only calibration commands while training; second one lands 8 cycles later
      fork
         begin
            u_ctrl.cal();
            wait_ck(5);
            u_ctrl.cal();
         end
         begin
            wait_ck(rd_latency + 3);
            for (int k = 0; k < 16; k++)
            begin
               check("dq_first", 16'(dq_first), 16'({8{pat[(2*k)%16]}} ^ 8'h55));
               check("dq_second", 16'(dq_second), 16'({8{pat[(2*k+1)%16]}} ^ 8'h55));
               check("strobe dmi", {7'h0, dqs_t_pair, dqs_c_pair, dmi_pair, dqs_oe, dq_oe, dmi_oe},
                  {7'h0, 4'h9, pat[(2*k)%16], pat[(2*k+1)%16], 3'h7});
               wait_ck(1);
            end
         end
      join
      check("static after burst", {11'h0, dqs_t_pair, dqs_c_pair, dqs_oe}, 16'h0007);
      u_ctrl.mrw(`MR_TCTL, 8'h00);
      wait_ck(12);
      check("training exit", {14'h0, dqs_oe, dq_oe}, 16'h0000);
      $display("test preamble training done");
      finish_test();
   end
endmodule
